// ---- design/ies_consts.svh ----
/*
  Register offsets, field positions, reset values and sizes of the
  I2C enable, status and FIFO level block.
  Assumes inclusion by bare name from the block's design file.
*/
`ifndef IES_CONSTS_SVH
`define IES_CONSTS_SVH

// APB byte addresses
`define IES_OFS_INT_MASK    16'h3820
`define IES_OFS_INT_RAW     16'h3834
`define IES_OFS_INT_CLR_ALL 16'h3840
`define IES_OFS_ABORT_CLR   16'h3854
`define IES_OFS_BUSY_CLR    16'h385c
`define IES_OFS_ENABLE      16'h386c
`define IES_OFS_STATUS      16'h3870
`define IES_OFS_TX_LEVEL    16'h3874
`define IES_OFS_RX_LEVEL    16'h3878
`define IES_OFS_ABORT_SRC   16'h3880

// Field positions
`define IES_EN_BIT          0
`define IES_ST_BUSY         0
`define IES_ST_TX_NFULL     1
`define IES_ST_TX_EMPTY     2
`define IES_ST_RX_NEMPTY    3
`define IES_ST_RX_FULL      4
`define IES_INT_ABORT       6
`define IES_INT_BUSY        8
`define IES_CLR_BIT         0
`define IES_SRC_ADDR7_NACK  0

// Reset values and sizes
`define IES_ENABLE_RST      16'h0000
`define IES_MASK_RST        16'h0000
`define IES_RAW_RST         16'h0000
`define IES_SRC_RST         16'h0000
`define IES_LEVEL_RST       4'h0
`define IES_FIFO_DEPTH      4'h8
`define IES_ONE             4'h1

`endif

// ---- design/ies_pkg.sv ----
/*
  Types shared by the I2C enable, status and FIFO level block.
  Assumes nothing of its surroundings.
*/
package ies_pkg;
  typedef logic [15:0] ies_reg_t;
  typedef logic [3:0]  ies_lvl_t;
  typedef logic [15:0] ies_addr_t;
endpackage

// ---- design/ies_ctrl.sv ----
/*
  Control and status part of an I2C controller: module enable, live
  status flags, transmit and receive FIFO level counters, abort cause
  register and a small interrupt group, all behind an APB slave.
  Assumes the protocol engine and FIFO data paths run on the same
  clock and report pushes, pops, busy and aborts as single-cycle
  pulses or levels; no synchronisers are therefore needed.
*/
`timescale 1ns/1ps
`include "ies_consts.svh"

// Operation
// RL1: Enable bit 0 set means module enabled, clear means disabled.
// RL2: Software must not clear enable while busy reads one.
// RL3: Disabling the module empties both transmit and receive FIFOs.
// RL4: Software shutdown: arm busy interrupt, last command, wait idle.
// RL5: Status bit 4 reads one only while the receive FIFO is full.
// RL6: Status bit 3 reads one while the receive FIFO holds data.
// RL7: Status bit 2 reads one when transmit FIFO empty; no interrupt.
// RL8: Status bit 1 reads one while the transmit FIFO has room.
// RL9: Status bit 0 shows live busy state and ignores writes.
// RL10: Transmit level counts up on push, down on pop.
// RL11: Transmit level zeroed on disable, transmit abort, bulk abort.
// RL12: Receive level counts up on store, down on read out.
// RL13: Receive level zeroed on disable or transmit abort.
// RL14: Abort source register records each abort cause as a bit.
// RL15: Abort source cleared by host read or general clear write.
// RL16: Reading busy clear register clears busy raw and masked status.
// RL17: Unacknowledged 7-bit address abort sets abort source bit 0.
// RL18: After reset module disabled, FIFOs empty, levels zero.
module ies_ctrl (
  input  wire logic                 i_clk,        // System clock
  input  wire logic                 i_rst,        // Sync reset, high
  input  wire logic                 psel,         // APB select
  input  wire logic                 penable,      // APB access phase
  input  wire logic                 pwrite,       // APB write
  input  wire ies_pkg::ies_addr_t   paddr,        // APB byte address
  input  wire logic [31:0]          pwdata,       // APB write data
  output logic                      pready,       // APB ready
  output logic [31:0]               prdata,       // APB read data
  output logic                      pslverr,      // APB error
  input  wire logic                 i_busy,       // Engine busy level
  input  wire logic                 i_tx_push,    // Transmit FIFO write
  input  wire logic                 i_tx_pop,     // Transmit FIFO read
  input  wire logic                 i_rx_push,    // Receive FIFO write
  input  wire logic                 i_rx_pop,     // Receive FIFO read
  input  wire logic                 i_abort,      // Transmit abort pulse
  input  wire ies_pkg::ies_reg_t    i_abort_src,  // Abort cause bits
  input  wire logic                 i_bulk_abort, // Slave bulk abort
  output logic                      o_enable,     // Module enabled
  output logic                      o_tx_flush,   // Empty transmit FIFO
  output logic                      o_rx_flush,   // Empty receive FIFO
  output logic                      o_tx_full,    // Transmit FIFO full
  output logic                      o_rx_full,    // Receive FIFO full
  output logic                      o_irq         // Interrupt level
);

  ies_pkg::ies_reg_t  enable_r;
  ies_pkg::ies_reg_t  mask_r;
  ies_pkg::ies_reg_t  raw_r;
  ies_pkg::ies_reg_t  raw_nxt;
  ies_pkg::ies_reg_t  src_r;
  ies_pkg::ies_reg_t  src_nxt;
  ies_pkg::ies_reg_t  status;
  ies_pkg::ies_reg_t  rdata_nxt;
  ies_pkg::ies_lvl_t  tx_lvl_r;
  ies_pkg::ies_lvl_t  rx_lvl_r;
  logic [31:0]        prdata_r;
  logic               err_r;
  logic               busy_d_r;
  logic               hit;
  logic               setup;
  logic               wr_done;
  logic               rd_done;
  logic               tx_full;
  logic               tx_empty;
  logic               rx_full;
  logic               rx_empty;
  logic               tx_inc;
  logic               tx_dec;
  logic               rx_inc;
  logic               rx_dec;
  logic               busy_event;
  logic               en;

  // Register decode strobes; side effects only fire on the access edge
  logic               wr_enable;
  logic               wr_mask;
  logic               wr_raw;
  logic               wr_clr_all;
  logic               rd_abort_clr;
  logic               rd_busy_clr;
  logic               rd_src;
  logic               src_clr;
  ies_pkg::ies_reg_t  evt;
  ies_pkg::ies_reg_t  clr;

  // Zero wait states: data is captured in setup, so access can end at once
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = err_r & psel & penable;

  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & pwrite;
  assign rd_done = psel & penable & ~pwrite;

  assign wr_enable    = wr_done & (paddr == `IES_OFS_ENABLE);
  assign wr_mask      = wr_done & (paddr == `IES_OFS_INT_MASK);
  assign wr_raw       = wr_done & (paddr == `IES_OFS_INT_RAW);
  assign wr_clr_all   = wr_done & (paddr == `IES_OFS_INT_CLR_ALL) &
                        pwdata[`IES_CLR_BIT];
  assign rd_abort_clr = rd_done & (paddr == `IES_OFS_ABORT_CLR);
  assign rd_busy_clr  = rd_done & (paddr == `IES_OFS_BUSY_CLR);
  assign rd_src       = rd_done & (paddr == `IES_OFS_ABORT_SRC);

  // RL1: Enable from bit 0
  assign en = enable_r[`IES_EN_BIT];

  // RL3: Flush on disable
  // RL11: Transmit flush causes
  assign o_tx_flush = ~en | i_abort | i_bulk_abort;
  // RL13: Receive flush causes
  assign o_rx_flush = ~en | i_abort;

  assign o_enable  = en;
  assign o_tx_full = tx_full;
  assign o_rx_full = rx_full;

  assign tx_full  = (tx_lvl_r == `IES_FIFO_DEPTH);
  assign tx_empty = (tx_lvl_r == `IES_LEVEL_RST);
  assign rx_full  = (rx_lvl_r == `IES_FIFO_DEPTH);
  assign rx_empty = (rx_lvl_r == `IES_LEVEL_RST);

  // Pushes into a full FIFO and pops from an empty one are ignored
  assign tx_inc = i_tx_push & ~tx_full;
  assign tx_dec = i_tx_pop & ~tx_empty;
  assign rx_inc = i_rx_push & ~rx_full;
  assign rx_dec = i_rx_pop & ~rx_empty;

  // Busy interrupt fires when the interface falls back to idle
  assign busy_event = busy_d_r & ~i_busy;

  // RL5: Receive full flag
  // RL6: Receive not empty flag
  // RL7: Transmit empty flag
  // RL8: Transmit not full flag
  // RL9: Live busy flag
  always_comb begin
    status                    = '0;
    status[`IES_ST_BUSY]      = i_busy;
    status[`IES_ST_TX_NFULL]  = ~tx_full;
    status[`IES_ST_TX_EMPTY]  = tx_empty;
    status[`IES_ST_RX_NEMPTY] = ~rx_empty;
    status[`IES_ST_RX_FULL]   = rx_full;
  end

  always_comb begin
    hit       = 1'b1;
    rdata_nxt = '0;
    case (paddr)
      `IES_OFS_INT_MASK:    rdata_nxt = mask_r;
      `IES_OFS_INT_RAW:     rdata_nxt = raw_r;
      `IES_OFS_INT_CLR_ALL: rdata_nxt = '0;
      `IES_OFS_ABORT_CLR:   rdata_nxt = '0;
      `IES_OFS_BUSY_CLR:    rdata_nxt = '0;
      `IES_OFS_ENABLE:      rdata_nxt = enable_r;
      `IES_OFS_STATUS:      rdata_nxt = status;
      `IES_OFS_TX_LEVEL:    rdata_nxt = {12'h000, tx_lvl_r};
      `IES_OFS_RX_LEVEL:    rdata_nxt = {12'h000, rx_lvl_r};
      `IES_OFS_ABORT_SRC:   rdata_nxt = src_r;
      default:              hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : {16'h0000, rdata_nxt};
      err_r    <= ~hit;
    end
  end

  // RL18: Disabled after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enable_r <= `IES_ENABLE_RST;
    end else if (wr_enable) begin
      // RL1: Only bit 0 is kept
      enable_r <= {15'h0000, pwdata[`IES_EN_BIT]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_r <= `IES_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_d_r <= 1'b0;
    end else begin
      busy_d_r <= i_busy;
    end
  end

  // RL10: Transmit level counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_lvl_r <= `IES_LEVEL_RST;
    end else if (o_tx_flush) begin
      // RL11: Flush zeroes level
      tx_lvl_r <= `IES_LEVEL_RST;
    end else if (tx_inc && !tx_dec) begin
      tx_lvl_r <= tx_lvl_r + `IES_ONE;
    end else if (tx_dec && !tx_inc) begin
      tx_lvl_r <= tx_lvl_r - `IES_ONE;
    end
  end

  // RL12: Receive level counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_lvl_r <= `IES_LEVEL_RST;
    end else if (o_rx_flush) begin
      // RL13: Flush zeroes level
      rx_lvl_r <= `IES_LEVEL_RST;
    end else if (rx_inc && !rx_dec) begin
      rx_lvl_r <= rx_lvl_r + `IES_ONE;
    end else if (rx_dec && !rx_inc) begin
      rx_lvl_r <= rx_lvl_r - `IES_ONE;
    end
  end

  // RL7: Only abort and busy raise interrupts
  always_comb begin
    evt                 = '0;
    evt[`IES_INT_ABORT] = i_abort;
    evt[`IES_INT_BUSY]  = busy_event;
  end

  // Raw status clears: write-one, general clear and read-to-clear
  always_comb begin
    clr = '0;
    if (wr_raw) begin
      clr = pwdata[15:0];
    end
    if (wr_clr_all) begin
      clr = '1;
    end
    if (rd_abort_clr) begin
      clr[`IES_INT_ABORT] = 1'b1;
    end
    // RL16: Busy clear on read
    if (rd_busy_clr) begin
      clr[`IES_INT_BUSY] = 1'b1;
    end
  end

  // One sticky bit per event; a set in the clearing cycle wins
  for (genvar b = 0; b < 16; b++) begin : g_raw
    assign raw_nxt[b] = (raw_r[b] & ~clr[b]) | evt[b];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      raw_r <= `IES_RAW_RST;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  // Masked status is raw AND mask; the line follows it
  assign o_irq = |(raw_r & mask_r);

  // Abort cause: a new cause in the clearing cycle survives
  // RL15: Clear on read or general clear
  assign src_clr = rd_src | rd_abort_clr | wr_clr_all;

  // RL14: Record causes
  // RL17: Address nack is bit 0
  for (genvar c = 0; c < 16; c++) begin : g_src
    assign src_nxt[c] = (src_r[c] & ~src_clr) | (i_abort & i_abort_src[c]);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_r <= `IES_SRC_RST;
    end else begin
      src_r <= src_nxt;
    end
  end

endmodule

// ---- verification/ies_ctrl_asserts.sv ----
/*
  Port checker for the I2C enable and status block, bound into it.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "ies_consts.svh"
module ies_chk (
  input wire logic               i_clk, i_rst, psel, penable, pwrite,
  input wire ies_pkg::ies_addr_t paddr,
  input wire logic [31:0]        pwdata, prdata,
  input wire logic               i_busy, i_tx_push, i_abort, i_bulk_abort,
  input wire logic               o_enable, o_tx_flush, o_rx_flush,
  input wire logic               o_tx_full, o_rx_full, o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_acc(a, w);
    psel && penable && (pwrite == w) && (paddr == a);
  endsequence
  chk_tx_flush_terms: assert property (
    o_tx_flush == (!o_enable || i_abort || i_bulk_abort))
    else $error("tx flush wrong");
  chk_rx_flush_terms: assert property (
    o_rx_flush == (!o_enable || i_abort)) else $error("rx flush wrong");
  chk_reset_idle: assert property ($past(i_rst) |->
    !o_enable && !o_tx_full && !o_rx_full && !o_irq)
    else $error("state after reset wrong");
  chk_enable_write: assert property (s_acc(`IES_OFS_ENABLE, 1) |=>
    o_enable == $past(pwdata[0])) else $error("enable not written");
  chk_tx_full_flush: assert property (o_tx_flush |=> !o_tx_full)
    else $error("tx full survives flush");
  chk_rx_full_flush: assert property (o_rx_flush |=> !o_rx_full)
    else $error("rx full survives flush");
  chk_busy_status: assert property (s_acc(`IES_OFS_STATUS, 0) |->
    prdata[0] == $past(i_busy)) else $error("busy status wrong");
  chk_tx_full_push: assert property ($rose(o_tx_full) |->
    $past(i_tx_push)) else $error("tx full without push");
endmodule
bind ies_ctrl ies_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .i_busy(i_busy), .i_tx_push(i_tx_push),
  .i_abort(i_abort), .i_bulk_abort(i_bulk_abort), .o_enable(o_enable),
  .o_tx_flush(o_tx_flush), .o_rx_flush(o_rx_flush),
  .o_tx_full(o_tx_full), .o_rx_full(o_rx_full), .o_irq(o_irq));

// ---- verification/ies_eng_model.sv ----
/*
  Behavioural serial engine: each start runs a short busy spell that
  ends with one received byte; a nack request gives an abort pulse.
  Assumes the block's clock; cause bits are garbage outside the pulse.
*/
`timescale 1ns/1ps
module ies_eng_model (
  input  wire logic  i_clk,       // Clock
  input  wire logic  i_rst,       // Sync reset, high
  input  wire logic  i_start,     // Begin one read byte
  input  wire logic  i_nack,      // Address not acknowledged
  output logic       o_busy,      // Transfer in progress
  output logic       o_rx_push,   // Byte received
  output logic       o_abort,     // Abort pulse
  output logic [15:0] o_abort_src // Abort cause bits
);
  logic [2:0] cnt_r;
  always_ff @(posedge i_clk)
    if (i_rst) cnt_r <= 3'h0;
    else if (i_start && cnt_r == 3'h0) cnt_r <= 3'h4;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  assign o_busy = (cnt_r != 3'h0);
  assign o_rx_push = (cnt_r == 3'h1);
  always_ff @(posedge i_clk) o_abort <= !i_rst && i_nack;
  assign o_abort_src = o_abort ? 16'h0001 : 16'hfffe;
endmodule

// ---- verification/test_i2c_enable_status_fifo_level.sv ----
/*
  Self-checking bench for ies_ctrl with an APB master and engine model.
  Assumes the design's zero-wait APB slave and byte addresses.
*/
`timescale 1ns/1ps
`include "ies_consts.svh"
module test_i2c_enable_status_fifo_level;
  logic i_clk, i_rst, psel, penable, pwrite, pready, pslverr;
  logic busy, rxp, abt, o_irq;
  logic [15:0] paddr, src;
  logic [31:0] prdata, pwdata, seed;
  logic [5:0] ev;
  logic [33:0] q[$];
  logic [33:0] e;
  int miscompares, n_checks, p;
  ies_ctrl i_dut (.i_clk(i_clk), .i_rst(i_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .i_busy(busy),
    .i_tx_push(ev[0]), .i_tx_pop(ev[1]), .i_rx_push(rxp),
    .i_rx_pop(ev[2]), .i_abort(abt), .i_abort_src(src),
    .i_bulk_abort(ev[3]), .o_enable(), .o_tx_flush(), .o_rx_flush(),
    .o_tx_full(), .o_rx_full(), .o_irq(o_irq));
  ies_eng_model i_eng (.i_clk(i_clk), .i_rst(i_rst), .i_start(ev[4]),
    .i_nack(ev[5]), .o_busy(busy), .o_rx_push(rxp), .o_abort(abt),
    .o_abort_src(src));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task cmp(input logic [32:0] g, input logic [32:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Reads queue their expectation; bit 33 marks an unchecked read
  task xfer(input logic w, input logic [15:0] a, input logic [33:0] d);
    @(posedge i_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d[31:0];
    if (!w) q.push_back(d);
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task ev_n(input int k, input int n);
    repeat (n) begin
      @(posedge i_clk); ev[k] <= 1'b1;
      @(posedge i_clk); ev[k] <= 1'b0;
    end
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    if (psel && penable && pready && !pwrite) begin
      e = q.pop_front();
      if (!e[33]) cmp({pslverr, prdata}, e[32:0]);
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #200us miscompares++;
    report_and_stop;
  end
  initial begin
    seed = 32'h2f; i_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 16'h0; pwdata = 32'h0; ev = 6'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    xfer(0, `IES_OFS_ENABLE, 34'h0);
    xfer(0, `IES_OFS_STATUS, 34'h6);
    xfer(0, `IES_OFS_TX_LEVEL, 34'h0);
    xfer(0, `IES_OFS_RX_LEVEL, 34'h0);
    xfer(1, `IES_OFS_ENABLE, 34'h1);
    xfer(0, `IES_OFS_ENABLE, 34'h1);
    ev_n(0, 9); // One push beyond full is dropped
    xfer(0, `IES_OFS_TX_LEVEL, 34'h8);
    xfer(0, `IES_OFS_STATUS, 34'h0);
    p = xs() % 4 + 1;
    ev_n(1, p);
    xfer(0, `IES_OFS_TX_LEVEL, 34'(8 - p));
    xfer(0, `IES_OFS_STATUS, 34'h2);
    ev_n(3, 1);
    xfer(0, `IES_OFS_TX_LEVEL, 34'h0);
    xfer(1, `IES_OFS_INT_MASK, 34'h100);
    xfer(0, `IES_OFS_BUSY_CLR, 34'h2_0000_0000);
    repeat (8) begin
      ev_n(4, 1);
      do @(posedge i_clk); while (busy);
    end
    xfer(0, `IES_OFS_RX_LEVEL, 34'h8);
    xfer(0, `IES_OFS_STATUS, 34'h1e);
    #1 cmp(o_irq, 1);
    xfer(0, `IES_OFS_BUSY_CLR, 34'h2_0000_0000);
    #1 cmp(o_irq, 0);
    ev_n(2, 1);
    xfer(0, `IES_OFS_STATUS, 34'he);
    xfer(0, `IES_OFS_RX_LEVEL, 34'h7);
    ev_n(0, 2);
    ev_n(5, 1);
    xfer(0, `IES_OFS_RX_LEVEL, 34'h0);
    xfer(0, `IES_OFS_TX_LEVEL, 34'h0);
    xfer(0, `IES_OFS_INT_RAW, 34'h40);
    #1 cmp(o_irq, 0);
    xfer(0, `IES_OFS_ABORT_SRC, 34'h1);
    xfer(0, `IES_OFS_ABORT_SRC, 34'h0);
    xfer(1, `IES_OFS_INT_MASK, 34'h40);
    #1 cmp(o_irq, 1);
    xfer(0, `IES_OFS_ABORT_CLR, 34'h2_0000_0000);
    #1 cmp(o_irq, 0);
    ev_n(5, 1);
    xfer(1, `IES_OFS_INT_CLR_ALL, 34'h1);
    xfer(0, `IES_OFS_ABORT_SRC, 34'h0);
    xfer(0, `IES_OFS_INT_RAW, 34'h0);
    xfer(0, 16'h3868, 34'h1_0000_0000); // Unmapped place is refused
    ev_n(0, 3);
    xfer(0, `IES_OFS_STATUS, 34'h2);
    xfer(1, `IES_OFS_ENABLE, 34'h0);
    xfer(0, `IES_OFS_TX_LEVEL, 34'h0);
    ev_n(0, 1);
    xfer(0, `IES_OFS_TX_LEVEL, 34'h0);
    repeat (2) @(posedge i_clk);
    report_and_stop;
  end
endmodule
